// *** logic/tru_pkg.sv ***
// Constants, carrier types and number formatting for the telemetry unit
// Operation
// - Input voltage adds chip current times filter resistance
// - Most readings return as linear 5s/11s words
// - Output voltage is unsigned mantissa, exponent from mode
// - Output current averaged, gain and temperature compensated
// - Report external and die temperatures in Celsius
// - Report switching frequency in kilohertz
// - Output power from latest correlated voltage, current
// - Input power from latest input voltage, current
// - Power accuracy byte, tenth percent per count
// - Maxima hold highest input and output voltage and current, and both temperatures; the unsigned input voltage compare keeps VAL_MIN for positive readings
// - Clear-maxima command resets every maximum
// - Selection zero samples all parameters round robin
// - Non-zero selection samples only that parameter
// - Selection change applies within two or three conversions
// - Single mode masks other faults, stops servoing
// - Selection codes map to fixed parameters
// - Reserved code samples die temperature, raises fault
// - Input voltage accuracy only in round robin
// - Selection is a write-only single byte
// - 48-bit elapsed counter, 200 us, shared timebase
// - Block read: length six, then bytes LSB first
// - Readable elapsed value refreshed every 25 ms
package tru_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CONV_MS = 8;
    localparam int CONV_CYC = CONV_MS * (CLK_HZ / 1000);
    localparam int RT_REFRESH_MS = 25;
    localparam int RT_REFRESH_CYC = RT_REFRESH_MS * (CLK_HZ / 1000);
    localparam int RT_RES_US = 200;
    localparam int SHARE_KHZ = 100;
    localparam int RT_TICKS = RT_RES_US * SHARE_KHZ / 1000;
    // Command codes
    localparam logic [7:0] CMD_VIN = 8'h88;
    localparam logic [7:0] CMD_IIN = 8'h89;
    localparam logic [7:0] CMD_VOUT = 8'h8b;
    localparam logic [7:0] CMD_IOUT = 8'h8c;
    localparam logic [7:0] CMD_ETEMP = 8'h8d;
    localparam logic [7:0] CMD_DTEMP = 8'h8e;
    localparam logic [7:0] CMD_FREQ = 8'h95;
    localparam logic [7:0] CMD_POUT = 8'h96;
    localparam logic [7:0] CMD_PIN = 8'h97;
    localparam logic [7:0] CMD_PIN_ACC = 8'hac;
    localparam logic [7:0] CMD_IOUT_MAX = 8'hd7;
    localparam logic [7:0] CMD_SEL = 8'hd8;
    localparam logic [7:0] CMD_VOUT_MAX = 8'hdd;
    localparam logic [7:0] CMD_VIN_MAX = 8'hde;
    localparam logic [7:0] CMD_ETEMP_MAX = 8'hdf;
    localparam logic [7:0] CMD_IIN_MAX = 8'he1;
    localparam logic [7:0] CMD_CLR_MAX = 8'he3;
    localparam logic [7:0] CMD_ICHIP = 8'he4;
    localparam logic [7:0] CMD_DTEMP_MAX = 8'hf4;
    localparam logic [7:0] CMD_RT = 8'hfb;
    localparam logic [7:0] RT_LEN = 8'h06;
    localparam logic [7:0] PIN_ACC_RST = 8'h32;
    localparam logic [7:0] SEL_RST = 8'h00;
    // Selection codes, also the conversion request codes
    localparam logic [3:0] SEL_RR = 4'h0;
    localparam logic [3:0] SEL_VIN = 4'h1;
    localparam logic [3:0] SEL_ICHIP = 4'h2;
    localparam logic [3:0] SEL_IIN = 4'h3;
    localparam logic [3:0] SEL_DTEMP = 4'h4;
    localparam logic [3:0] SEL_VOUT0 = 4'h5;
    localparam logic [3:0] SEL_IOUT0 = 4'h6;
    localparam logic [3:0] SEL_ETEMP0 = 4'h8;
    localparam logic [3:0] SEL_VOUT1 = 4'h9;
    localparam logic [3:0] SEL_IOUT1 = 4'ha;
    localparam logic [3:0] SEL_ETEMP1 = 4'hc;
    localparam int RR_LEN = 10;
    localparam logic [39:0] RR_LIST = {SEL_ETEMP1, SEL_IOUT1, SEL_VOUT1,
        SEL_ETEMP0, SEL_IOUT0, SEL_VOUT0, SEL_DTEMP, SEL_IIN, SEL_ICHIP,
        SEL_VIN};
    // Binary exponents of the internal raw values
    localparam int EXP_V = -8;
    localparam int EXP_I = -6;
    localparam int EXP_T = -4;
    localparam int EXP_F = 0;
    localparam int EXP_PIN = -14;
    localparam int EXP_POUT = -10;
    localparam int EXP_VOUT = -12;
    localparam int EXP_ICHIP = -10;
    localparam logic signed [23:0] T_REF_RAW = 24'sh0001b0;
    localparam logic signed [23:0] VAL_MIN = 24'sh800000;

    typedef struct packed {
        logic signed [15:0] gain;
        logic signed [15:0] tempco;
        logic signed [15:0] tgain;
        logic signed [15:0] toffset;
    } tru_ccfg_s;
    typedef struct packed {
        logic [15:0] rvin;
        logic signed [4:0] vout_exp;
        tru_ccfg_s [1:0] ch;
    } tru_cfg_s;
    typedef struct packed {
        logic req;
        logic write;
        logic [7:0] code;
        logic page;
        logic [2:0] idx;
        logic [7:0] wdata;
    } tru_cmd_s;
    typedef struct packed {
        logic ack;
        logic bad;
        logic [7:0] data;
    } tru_rsp_s;
    typedef struct packed {
        logic done;
        logic [3:0] code;
        logic signed [23:0] value;
    } tru_adc_s;
    typedef struct packed {
        logic done;
        logic ch;
        logic [15:0] khz;
    } tru_freq_s;
    typedef struct packed {
        logic start;
        logic [3:0] code;
        logic [15:0] fault_en;
        logic servo_en;
        logic cml_fault;
        logic vin_acc_ok;
    } tru_ctl_s;
    typedef struct packed {
        logic [23:0] vout;
        logic signed [23:0] iout;
        logic signed [23:0] etemp;
        logic signed [23:0] freq;
        logic signed [47:0] pout;
        logic [23:0] vout_max;
        logic signed [23:0] iout_max;
        logic signed [23:0] etemp_max;
    } tru_chan_s;
    typedef struct packed {
        logic [7:0] sel;
        logic [31:0] slot_cnt;
        logic [3:0] rr_idx;
        logic signed [23:0] vin;
        logic signed [23:0] iin;
        logic signed [23:0] ichip;
        logic signed [23:0] dtemp;
        logic signed [47:0] pin;
        logic signed [23:0] vin_max;
        logic signed [23:0] iin_max;
        logic signed [23:0] dtemp_max;
        tru_chan_s [1:0] ch;
        logic [2:0] sh_sync;
        logic sh_lvl;
        logic [7:0] rt_div;
        logic [47:0] rt_cnt;
        logic [47:0] rt_snap;
        logic [31:0] rt_ref;
        tru_rsp_s rsp;
        tru_ctl_s ctl;
    } tru_state_s;

    // Normalise a signed value into a 5-bit exponent, 11-bit mantissa word
    function automatic logic [15:0] tru_l11(input logic signed [47:0] v,
                                            input int e0);
        logic signed [47:0] m;
        int e;
        m = v;
        e = e0;
        for (int k = 0; k < 40; k++) begin
            if (m > 48'sd1023 || m < -48'sd1024) begin
                m = m >>> 1;
                e = e + 1;
            end
        end
        return {e[4:0], m[10:0]};
    endfunction

    // Rescale raw output voltage to the mantissa of the mode exponent
    function automatic logic [15:0] tru_l16(input logic [23:0] raw,
                                            input logic signed [4:0] e);
        logic [47:0] m;
        int s;
        m = {24'h0, raw};
        s = int'(e) - EXP_VOUT;
        if (s >= 0) begin
            m = m >> s;
        end else begin
            m = m << (-s);
        end
        if (m > 48'h00ffff) begin
            m = 48'h00ffff;
        end
        return m[15:0];
    endfunction
endpackage

// *** logic/tru_telemetry.sv ***
// Telemetry read-back unit: readings, maxima, selection, elapsed time
`timescale 1ns/100ps
module tru_telemetry #(
    parameter int CONV_CYC_P = tru_pkg::CONV_CYC,
    parameter int RT_REFRESH_CYC_P = tru_pkg::RT_REFRESH_CYC
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Command port from the bus engine
    input wire tru_pkg::tru_cmd_s cmd_in,
    output tru_pkg::tru_rsp_s rsp_out,
    // Conversion results and configuration
    input wire tru_pkg::tru_adc_s adc_in,
    input wire tru_pkg::tru_freq_s freq_in,
    input wire tru_pkg::tru_cfg_s cfg_in,
    // Shared timebase pin
    input wire logic share_clk_in,
    // Conversion request and supervision controls
    output tru_pkg::tru_ctl_s ctl_out
);
    import tru_pkg::*;

    function automatic tru_state_s rst_state();
        tru_state_s s;
        s = '0;
        s.sel = SEL_RST;
        s.vin_max = VAL_MIN;
        s.iin_max = VAL_MIN;
        s.dtemp_max = VAL_MIN;
        for (int c = 0; c < 2; c++) begin
            s.ch[c].iout_max = VAL_MIN;
            s.ch[c].etemp_max = VAL_MIN;
        end
        s.ctl.fault_en = 16'hffff;
        s.ctl.servo_en = 1'b1;
        s.ctl.vin_acc_ok = 1'b1;
        return s;
    endfunction
    localparam tru_state_s RST_ST = rst_state();

    tru_state_s st_ff;
    tru_state_s nxt_st;
    logic signed [23:0] etemp_new [2];
    logic signed [23:0] iout_new [2];
    logic signed [47:0] pout_new [2];

    // Per-channel temperature, current and power arithmetic
    genvar g;
    for (g = 0; g < 2; g++) begin : g_ch
        logic signed [47:0] t_cal;
        logic signed [47:0] i_inst;
        logic signed [47:0] fac;
        logic signed [47:0] i_cor;
        logic signed [24:0] i_sum;
        assign t_cal = ((adc_in.value * cfg_in.ch[g].tgain) >>> 14)
            + cfg_in.ch[g].toffset;
        assign etemp_new[g] = t_cal[23:0];
        assign i_inst = (adc_in.value * cfg_in.ch[g].gain) >>> 10;
        assign fac = 48'sd16384 - ((cfg_in.ch[g].tempco
            * (st_ff.ch[g].etemp - T_REF_RAW)) >>> 10);
        assign i_cor = (i_inst * fac) >>> 14;
        assign i_sum = $signed({st_ff.ch[g].iout[23], st_ff.ch[g].iout})
            + $signed({i_cor[23], i_cor[23:0]});
        assign iout_new[g] = i_sum[24:1];
        assign pout_new[g] = ($signed({1'b0, st_ff.ch[g].vout})
            * iout_new[g]) >>> 8;
    end

    always_comb begin
        logic signed [47:0] vin_c;
        logic clr;
        logic sel_ok;
        logic [3:0] eff;
        logic [15:0] w;
        logic kind_word;
        logic bad;
        tru_chan_s cp;
        nxt_st = st_ff;
        vin_c = '0;
        w = '0;
        kind_word = 1'b1;
        bad = 1'b0;
        sel_ok = 1'b0;
        eff = '0;
        cp = st_ff.ch[cmd_in.page];
        clr = cmd_in.req && cmd_in.write && cmd_in.code == CMD_CLR_MAX;
        nxt_st.rsp = '0;
        nxt_st.ctl.start = 1'b0;

        // Command decode: reads answer one byte, writes set selection or clear maxima
        if (cmd_in.req) begin
            unique case (cmd_in.code)
                CMD_VIN: w = tru_l11(48'(st_ff.vin), EXP_V);
                CMD_IIN: w = tru_l11(48'(st_ff.iin), EXP_I);
                CMD_VOUT: w = tru_l16(cp.vout, cfg_in.vout_exp);
                CMD_IOUT: w = tru_l11(48'(cp.iout), EXP_I);
                CMD_ETEMP: w = tru_l11(48'(cp.etemp), EXP_T);
                CMD_DTEMP: w = tru_l11(48'(st_ff.dtemp), EXP_T);
                CMD_FREQ: w = tru_l11(48'(cp.freq), EXP_F);
                CMD_POUT: w = tru_l11(cp.pout, EXP_POUT);
                CMD_PIN: w = tru_l11(st_ff.pin, EXP_PIN);
                CMD_ICHIP: w = tru_l11(48'(st_ff.ichip), EXP_ICHIP);
                CMD_IOUT_MAX: w = tru_l11(48'(cp.iout_max), EXP_I);
                CMD_VOUT_MAX: w = tru_l16(cp.vout_max, cfg_in.vout_exp);
                CMD_VIN_MAX: w = tru_l11(48'(st_ff.vin_max), EXP_V);
                CMD_ETEMP_MAX: w = tru_l11(48'(cp.etemp_max), EXP_T);
                CMD_IIN_MAX: w = tru_l11(48'(st_ff.iin_max), EXP_I);
                CMD_DTEMP_MAX: w = tru_l11(48'(st_ff.dtemp_max), EXP_T);
                CMD_PIN_ACC: begin
                    kind_word = 1'b0;
                    w = {8'h00, PIN_ACC_RST};
                    bad = cmd_in.idx != 3'd0;
                end
                CMD_RT: begin
                    kind_word = 1'b0;
                    if (cmd_in.idx == 3'd0) begin
                        w = {8'h00, RT_LEN};
                    end else if (cmd_in.idx == 3'd7) begin
                        bad = 1'b1;
                    end else begin
                        w = {8'h00,
                            st_ff.rt_snap[{cmd_in.idx - 3'd1, 3'b000} +: 8]};
                    end
                end
                CMD_SEL: begin
                    kind_word = 1'b0;
                    bad = !cmd_in.write;
                    if (cmd_in.write) begin
                        nxt_st.sel = cmd_in.wdata;
                    end
                end
                CMD_CLR_MAX: begin
                    kind_word = 1'b0;
                    bad = !cmd_in.write;
                end
                default: begin
                    kind_word = 1'b0;
                    bad = 1'b1;
                end
            endcase
            if (kind_word) begin
                bad = cmd_in.write || cmd_in.idx > 3'd1;
            end else if (cmd_in.code != CMD_SEL
                         && cmd_in.code != CMD_CLR_MAX) begin
                bad = bad || cmd_in.write;
            end
            nxt_st.rsp.ack = 1'b1;
            nxt_st.rsp.bad = bad;
            if (!bad && !cmd_in.write) begin
                nxt_st.rsp.data = cmd_in.idx[0] && kind_word ?
                    w[15:8] : w[7:0];
            end
        end

        // Clear first so that a reading in the same cycle still lands
        if (clr) begin
            nxt_st.vin_max = VAL_MIN;
            nxt_st.iin_max = VAL_MIN;
            nxt_st.dtemp_max = VAL_MIN;
            for (int c = 0; c < 2; c++) begin
                nxt_st.ch[c].vout_max = '0;
                nxt_st.ch[c].iout_max = VAL_MIN;
                nxt_st.ch[c].etemp_max = VAL_MIN;
            end
        end

        // Conversion results update readings and maxima
        if (adc_in.done) begin
            if (adc_in.code == SEL_VIN) begin
                vin_c = adc_in.value + ((st_ff.ichip
                    * $signed({1'b0, cfg_in.rvin})) >>> 12);
                nxt_st.vin = vin_c[23:0];
                if (vin_c[23:0] > nxt_st.vin_max) begin
                    nxt_st.vin_max = vin_c[23:0];
                end
            end
            if (adc_in.code == SEL_ICHIP) begin
                nxt_st.ichip = adc_in.value;
            end
            if (adc_in.code == SEL_IIN) begin
                nxt_st.iin = adc_in.value;
                if (adc_in.value > nxt_st.iin_max) begin
                    nxt_st.iin_max = adc_in.value;
                end
            end
            if (adc_in.code == SEL_DTEMP) begin
                nxt_st.dtemp = adc_in.value;
                if (adc_in.value > nxt_st.dtemp_max) begin
                    nxt_st.dtemp_max = adc_in.value;
                end
            end
            for (int c = 0; c < 2; c++) begin
                if (adc_in.code == (c == 1 ? SEL_VOUT1 : SEL_VOUT0)) begin
                    nxt_st.ch[c].vout = adc_in.value;
                    if (adc_in.value > nxt_st.ch[c].vout_max) begin
                        nxt_st.ch[c].vout_max = adc_in.value;
                    end
                end
                if (adc_in.code == (c == 1 ? SEL_IOUT1 : SEL_IOUT0)) begin
                    nxt_st.ch[c].iout = iout_new[c];
                    nxt_st.ch[c].pout = pout_new[c];
                    if (iout_new[c] > nxt_st.ch[c].iout_max) begin
                        nxt_st.ch[c].iout_max = iout_new[c];
                    end
                end
                if (adc_in.code == (c == 1 ? SEL_ETEMP1 : SEL_ETEMP0)) begin
                    nxt_st.ch[c].etemp = etemp_new[c];
                    if (etemp_new[c] > nxt_st.ch[c].etemp_max) begin
                        nxt_st.ch[c].etemp_max = etemp_new[c];
                    end
                end
            end
        end
        if (freq_in.done) begin
            nxt_st.ch[freq_in.ch].freq = {8'h00, freq_in.khz};
        end
        nxt_st.pin = st_ff.vin * st_ff.iin;

        // Selection decode and supervision controls
        sel_ok = nxt_st.sel[7:4] == 4'h0 && nxt_st.sel[3:0] inside
            {SEL_VIN, SEL_ICHIP, SEL_IIN, SEL_DTEMP, SEL_VOUT0, SEL_IOUT0,
             SEL_ETEMP0, SEL_VOUT1, SEL_IOUT1, SEL_ETEMP1};
        eff = sel_ok ? nxt_st.sel[3:0] : SEL_DTEMP;
        if (nxt_st.sel == SEL_RST) begin
            nxt_st.ctl.fault_en = 16'hffff;
            nxt_st.ctl.servo_en = 1'b1;
            nxt_st.ctl.cml_fault = 1'b0;
            nxt_st.ctl.vin_acc_ok = 1'b1;
        end else begin
            nxt_st.ctl.fault_en = 16'h0001 << eff;
            nxt_st.ctl.servo_en = 1'b0;
            nxt_st.ctl.cml_fault = !sel_ok;
            nxt_st.ctl.vin_acc_ok = 1'b0;
        end

        // Conversion slots: round robin or the single selected code
        if (st_ff.slot_cnt >= 32'(CONV_CYC_P - 1)) begin
            nxt_st.slot_cnt = '0;
            nxt_st.ctl.start = 1'b1;
            if (nxt_st.sel == SEL_RST) begin
                nxt_st.ctl.code = RR_LIST[{st_ff.rr_idx, 2'b00} +: 4];
                nxt_st.rr_idx = st_ff.rr_idx == 4'(RR_LEN - 1) ?
                    4'h0 : st_ff.rr_idx + 4'h1;
            end else begin
                nxt_st.ctl.code = eff;
            end
        end else begin
            nxt_st.slot_cnt = st_ff.slot_cnt + 32'h1;
        end

        // Shared timebase: three-stage sync, edges divided to 200 us
        nxt_st.sh_sync = {st_ff.sh_sync[1:0], share_clk_in};
        if (st_ff.sh_sync[1] == st_ff.sh_sync[2]) begin
            nxt_st.sh_lvl = st_ff.sh_sync[2];
        end
        if (nxt_st.sh_lvl && !st_ff.sh_lvl) begin
            if (st_ff.rt_div >= 8'(RT_TICKS - 1)) begin
                nxt_st.rt_div = '0;
                nxt_st.rt_cnt = st_ff.rt_cnt + 48'h1;
            end else begin
                nxt_st.rt_div = st_ff.rt_div + 8'h1;
            end
        end
        if (st_ff.rt_ref >= 32'(RT_REFRESH_CYC_P - 1)) begin
            nxt_st.rt_ref = '0;
            nxt_st.rt_snap = st_ff.rt_cnt;
        end else begin
            nxt_st.rt_ref = st_ff.rt_ref + 32'h1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            st_ff <= RST_ST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rsp_out = st_ff.rsp;
    assign ctl_out = st_ff.ctl;

    logic clr_w;
    assign clr_w = cmd_in.req && cmd_in.write && cmd_in.code == CMD_CLR_MAX;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);

    a_rt_length: assert property (cmd_in.req && !cmd_in.write
        && cmd_in.code == CMD_RT && cmd_in.idx == 3'd0
        |=> rsp_out.ack && !rsp_out.bad && rsp_out.data == RT_LEN)
        else $error("elapsed block length not six");
    a_reserved_fault: assert property (cmd_in.req && cmd_in.write
        && cmd_in.code == CMD_SEL && cmd_in.wdata == 8'h07
        |=> ctl_out.cml_fault && !ctl_out.servo_en)
        else $error("reserved selection without fault");
    a_rr_restore: assert property (cmd_in.req && cmd_in.write
        && cmd_in.code == CMD_SEL && cmd_in.wdata == 8'h00
        |=> ctl_out.servo_en && ctl_out.fault_en == 16'hffff)
        else $error("round robin did not restore supervision");
    a_max_track: assert property (adc_in.done && !clr_w
        && adc_in.code == SEL_IIN
        |=> st_ff.iin_max >= st_ff.iin)
        else $error("input current maximum below reading");
    a_max_clear: assert property (clr_w && !adc_in.done
        |=> st_ff.iin_max == VAL_MIN && st_ff.vin_max == VAL_MIN)
        else $error("maxima not cleared");
    a_rt_step: assert property (st_ff.rt_cnt != $past(st_ff.rt_cnt)
        |-> st_ff.rt_cnt == $past(st_ff.rt_cnt) + 48'h1)
        else $error("elapsed counter jumped");
    a_snap_time: assert property (st_ff.rt_snap != $past(st_ff.rt_snap)
        |-> $past(st_ff.rt_ref) == 32'(RT_REFRESH_CYC_P - 1))
        else $error("elapsed snapshot outside refresh");
    a_start_gap: assert property (ctl_out.start
        |=> !ctl_out.start [*8])
        else $error("conversion starts too close");
    a_single_code: assert property (ctl_out.start
        && (st_ff.sel == 8'h05 || st_ff.sel == 8'h0c)
        |-> ctl_out.code == st_ff.sel[3:0])
        else $error("single mode converts wrong parameter");
    a_reserved_die: assert property (ctl_out.start
        && st_ff.sel == 8'h0b |-> ctl_out.code == SEL_DTEMP)
        else $error("reserved code not die temperature");
    a_vin_acc: assert property (ctl_out.vin_acc_ok
        == (st_ff.sel == SEL_RST))
        else $error("input voltage accuracy flag wrong");
    a_sel_decode: assert property (cmd_in.req && cmd_in.write
        && cmd_in.code == CMD_SEL && cmd_in.wdata == 8'h05
        |=> ctl_out.fault_en == 16'h0020 && !ctl_out.cml_fault)
        else $error("selection code decode wrong");
    a_rt_bad_idx: assert property (cmd_in.req && !cmd_in.write
        && cmd_in.code == CMD_RT && cmd_in.idx == 3'd7 |=> rsp_out.bad)
        else $error("elapsed block index seven accepted");
    a_acc_byte: assert property (cmd_in.req && !cmd_in.write
        && cmd_in.code == CMD_PIN_ACC && cmd_in.idx == 3'd0
        |=> rsp_out.data == PIN_ACC_RST)
        else $error("accuracy byte wrong");

    c_single: cover property (ctl_out.start && ctl_out.code == SEL_ETEMP1
        && st_ff.sel != 8'h00);
    c_read_ok: cover property (rsp_out.ack && !rsp_out.bad);
    c_fault: cover property (ctl_out.cml_fault);
    c_rt_tick: cover property (st_ff.rt_cnt != $past(st_ff.rt_cnt));
    c_clear: cover property (clr_w);
endmodule

// *** verif/tru_adc_model.sv ***
// Conversion front-end stand-in that answers each start request
`timescale 1ns/100ps
module tru_adc_model (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Requests and the value to return
    input wire tru_pkg::tru_ctl_s ctl_in,
    input wire logic signed [23:0] val_in,
    // Results
    output tru_pkg::tru_adc_s adc_out
);
    import tru_pkg::*;
    logic [2:0] dly_ff;
    logic [3:0] code_ff;
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            dly_ff <= 3'h0;
            code_ff <= 4'h0;
            adc_out <= '0;
        end else begin
            dly_ff <= {dly_ff[1:0], ctl_in.start};
            if (ctl_in.start) begin
                code_ff <= ctl_in.code;
            end
            // Lines carry scrambled values outside the result pulse
            adc_out.done <= dly_ff[2];
            adc_out.code <= dly_ff[2] ? code_ff : ~code_ff;
            adc_out.value <= dly_ff[2] ? val_in : ~adc_out.value;
        end
    end
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the telemetry read-back unit
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
    err_total++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb;
    import tru_pkg::*;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic signed [23:0] val = 24'sh000064;
    tru_cmd_s cmd = '0;
    tru_rsp_s rsp;
    tru_adc_s adc;
    tru_ctl_s ctl;
    tru_freq_s frq = '0;
    tru_cfg_s cfg = {16'h1000, 133'h0};
    logic [2:0] sh_cnt = 3'h0;
    logic sh_run = 1'b0;
    int err_total = 0;
    int n_checks = 0;
    logic [3:0] c;
    logic [39:0] rsv = {4'hf, 4'he, 4'hd, 4'hb, 4'h7};
    always #10 clock_in = ~clock_in;
    always @(posedge clock_in) sh_cnt <= sh_cnt + 3'h1;
    tru_telemetry #(.CONV_CYC_P(20), .RT_REFRESH_CYC_P(50)) tru_telemetry_i (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .cmd_in(cmd),
        .rsp_out(rsp), .adc_in(adc), .freq_in(frq), .cfg_in(cfg),
        .share_clk_in(sh_run & sh_cnt[2]), .ctl_out(ctl));
    tru_adc_model tru_adc_model_i (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .ctl_in(ctl), .val_in(val), .adc_out(adc));
    task close_out;
        $display("Checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task xf(input logic w, input logic [7:0] cd, input logic [2:0] i,
            input logic [7:0] d, input logic [7:0] ed, input logic eb);
        @(posedge clock_in);
        cmd <= '{1'b1, w, cd, 1'b0, i, d};
        @(posedge clock_in);
        cmd.req <= 1'b0;
        #1;
        `CHK("ack", 1'b1, rsp.ack)
        `CHK("bad", eb, rsp.bad)
        `CHK("data", ed, rsp.data)
    endtask
    task rdw(input logic [7:0] cd, input logic [15:0] e);
        xf(1'b0, cd, 3'h0, 8'h00, e[7:0], 1'b0);
        xf(1'b0, cd, 3'h1, 8'h00, e[15:8], 1'b0);
    endtask
    task wait_st(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge clock_in);
                #1;
                k++;
            end while (ctl.start !== 1'b1 && k < 100);
            if (k >= 100) begin
                err_total++;
                close_out();
            end
        end
    endtask
    initial begin
        repeat (3) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        #1;
        `CHK("rsp", 10'h000, rsp)
        `CHK("servo", 1'b1, ctl.servo_en)
        `CHK("fault_en", 16'hffff, ctl.fault_en)
        `CHK("vin_acc", 1'b1, ctl.vin_acc_ok)
        for (int k = 0; k < 12 && ctl.code !== SEL_VIN; k++) wait_st(1);
        for (int k = 1; k < 10; k++) begin
            wait_st(1);
            `CHK("rr code", RR_LIST[4*k +: 4], ctl.code)
        end
        xf(1'b0, CMD_PIN_ACC, 3'h0, 8'h00, 8'h32, 1'b0);
        xf(1'b0, CMD_RT, 3'h0, 8'h00, 8'h06, 1'b0);
        xf(1'b0, CMD_RT, 3'h1, 8'h00, 8'h00, 1'b0);
        xf(1'b0, CMD_RT, 3'h7, 8'h00, 8'h00, 1'b1);
        xf(1'b0, CMD_SEL, 3'h0, 8'h00, 8'h00, 1'b1);
        xf(1'b1, CMD_VIN, 3'h0, 8'h12, 8'h00, 1'b1);
        for (int k = 0; k < 10; k++) begin
            c = RR_LIST[4*k +: 4];
            xf(1'b1, CMD_SEL, 3'h0, {4'h0, c}, 8'h00, 1'b0);
            `CHK("fault_en", 16'h0001 << c, ctl.fault_en)
            `CHK("servo", 1'b0, ctl.servo_en)
            `CHK("vin_acc", 1'b0, ctl.vin_acc_ok)
            wait_st(2);
            `CHK("sel code", c, ctl.code)
        end
        for (int k = 0; k < 5; k++) begin
            c = rsv[4*k +: 4];
            xf(1'b1, CMD_SEL, 3'h0, {4'h0, c}, 8'h00, 1'b0);
            `CHK("cml", 1'b1, ctl.cml_fault)
            wait_st(2);
            `CHK("rsv code", SEL_DTEMP, ctl.code)
        end
        xf(1'b1, CMD_SEL, 3'h0, 8'h00, 8'h00, 1'b0);
        `CHK("cml", 1'b0, ctl.cml_fault)
        `CHK("servo", 1'b1, ctl.servo_en)
        xf(1'b1, CMD_SEL, 3'h0, 8'h03, 8'h00, 1'b0);
        wait_st(3);
        repeat (6) @(posedge clock_in);
        rdw(CMD_IIN, 16'hd064);
        rdw(CMD_IIN_MAX, 16'hd064);
        rdw(CMD_VIN, 16'hc0c8);
        rdw(CMD_PIN, 16'hba71);
        @(posedge clock_in);
        frq <= '{1'b1, 1'b0, 16'h0190};
        @(posedge clock_in);
        frq.done <= 1'b0;
        rdw(CMD_FREQ, 16'h0190);
        val <= 24'sh000032;
        wait_st(2);
        repeat (6) @(posedge clock_in);
        rdw(CMD_IIN, 16'hd032);
        rdw(CMD_IIN_MAX, 16'hd064);
        xf(1'b1, CMD_CLR_MAX, 3'h0, 8'h00, 8'h00, 1'b0);
        wait_st(2);
        repeat (6) @(posedge clock_in);
        rdw(CMD_IIN_MAX, 16'hd032);
        @(posedge clock_in);
        sh_run <= 1'b1;
        repeat (1000) @(posedge clock_in);
        cmd <= '{1'b1, 1'b0, CMD_RT, 1'b0, 3'h1, 8'h00};
        @(posedge clock_in);
        cmd.req <= 1'b0;
        #1;
        `CHK("rt lsb", 1'b1, rsp.data inside {8'h05, 8'h06})
        close_out();
    end
endmodule
